// File: dpb4_array.sv
`timescale 1ns/1ns
`default_nettype none
module dpb4_array #(
   parameter int AW = 8,
   parameter int W = 18,
   parameter int L = 2
) (
   input wire logic i_core_clk,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [4*W-1:0] i_wdata,
   input wire logic [4*L-1:0] i_wmask,
   input wire logic [AW-1:0] i_raddr,
   input wire logic [1:0] i_ridx,
   output logic [W-1:0] o_rdata
);
   localparam int LW = W / L;
   logic [W-1:0] mem [0:(4<<AW)-1];

   // ----------------------------------------
   // lane-masked burst write
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < L; j++) begin
            if (i_we && i_wmask[i*L+j]) begin // RL14
               mem[{i_waddr, 2'(i)}][j*LW +: LW] <= i_wdata[i*W+j*LW +: LW];
            end
         end
      end
   end

   assign o_rdata = mem[{i_raddr, i_ridx}];
endmodule // dpb4_array
`default_nettype wire

// File: dpb4_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module dpb4_asserts
   import dpb4_pkg::*;
#(
   parameter int L = 2
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic k_pos,
   input wire logic c_pos,
   input wire logic c_neg,
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   input wire logic [L-1:0] byte_lane_write_select_n,
   input wire logic q_oe
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   // ------------------------------------------------
   // granted starts, as the device should see them
   // ------------------------------------------------
   logic rd_sel;
   logic wr_sel;
   logic rd_go;
   logic wr_go;
   dpb4_start_t last_q;
   logic [5:0] rd_sh_q;
   logic [5:0] wr_sh_q;
   assign rd_sel = k_pos && !read_port_select_n;
   assign wr_sel = k_pos && !write_port_select_n;
   assign rd_go = rd_sel && (last_q != DPB4_READ);
   assign wr_go = wr_sel && !rd_go && (last_q != DPB4_WRITE);
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         last_q <= DPB4_NONE;
      end else if (k_pos) begin
         last_q <= rd_go ? DPB4_READ : (wr_go ? DPB4_WRITE : DPB4_NONE);
      end
   end
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_sh_q <= 6'h00;
         wr_sh_q <= 6'h00;
      end else begin
         rd_sh_q <= {rd_sh_q[4:0], rd_go};
         wr_sh_q <= {wr_sh_q[4:0], wr_go};
      end
   end
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   kclk_toggle_a: assert property (k_pos |=> !k_pos)
      else $error("input clock phase did not alternate");
   out_clk_a: assert property ((c_pos && c_neg) ||
      (c_pos == k_pos && c_neg == !k_pos))
      else $error("output clock pair out of step");
   one_start_a: assert property (!(rd_sel && wr_sel))
      else $error("read and write selected together");
   rd_space_a: assert property (rd_sel |-> last_q != DPB4_READ)
      else $error("read select right after a read start");
   wr_space_a: assert property (wr_sel |-> last_q != DPB4_WRITE)
      else $error("write select right after a write start");
   q_window_a: assert property (q_oe == |rd_sh_q[5:2])
      else $error("read output enable outside its window");
   rd_burst_a: assert property (rd_go |-> ##3 q_oe [*4])
      else $error("read burst not four cycles long");
   lane_idle_a: assert property (
      wr_sh_q[4:1] == 4'h0 |-> &byte_lane_write_select_n)
      else $error("lane select active outside write data");
   rd_c: cover property (rd_go);
   wr_c: cover property (wr_go);
   mix_c: cover property (wr_go ##2 rd_go);
endmodule // dpb4_asserts
`default_nettype wire

// File: dpb4_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "dpb4_params.svh"
module dpb4_ctrl
   import dpb4_pkg::*;
#(
   parameter int AW = `DPB4_ADDR_W,
   parameter int W = `DPB4_WORD_W,
   parameter int L = `DPB4_LANES
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_single_clk,
   input wire logic i_rd_req,
   input wire logic [AW-1:0] i_rd_addr,
   input wire logic i_wr_req,
   input wire logic [AW-1:0] i_wr_addr,
   input wire logic [4*W-1:0] i_wr_data,
   input wire logic [4*L-1:0] i_wr_lane_en,
   output logic o_rd_ack,
   output logic o_wr_ack,
   output logic o_rd_valid,
   output logic [4*W-1:0] o_rd_data,
   dpb4_if.ctrl bus
);
   // ----------------------------------------
   // clocks and issue
   // ----------------------------------------
   logic kpos_q, cp_q, cn_q, rps_n_q, wps_n_q;
   logic [AW-1:0] addr_q;
   dpb4_start_t last_q;
   logic iss_rd, iss_wr;

   assign iss_rd = !kpos_q && i_rd_req && last_q != DPB4_READ; // RL17
   assign iss_wr = !kpos_q && !iss_rd && i_wr_req && last_q != DPB4_WRITE;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         kpos_q <= 1'b0;
         cp_q <= 1'b1;
         cn_q <= 1'b1;
         rps_n_q <= 1'b1;
         wps_n_q <= 1'b1;
         addr_q <= '0;
         last_q <= DPB4_NONE;
         o_rd_ack <= 1'b0;
         o_wr_ack <= 1'b0;
      end else begin
         kpos_q <= ~kpos_q;
         cp_q <= i_single_clk | ~kpos_q; // RL15
         cn_q <= i_single_clk | kpos_q;
         rps_n_q <= ~iss_rd; // RL6
         wps_n_q <= ~iss_wr; // RL10
         o_rd_ack <= iss_rd;
         o_wr_ack <= iss_wr;
         if (iss_rd) begin
            addr_q <= i_rd_addr;
         end else if (iss_wr) begin
            addr_q <= i_wr_addr;
         end
         if (!kpos_q) begin
            last_q <= iss_rd ? DPB4_READ : (iss_wr ? DPB4_WRITE : DPB4_NONE);
         end
      end
   end

   // ----------------------------------------
   // write data words, t+1 and t+2
   // ----------------------------------------
   logic [2:0] wseq_q;
   logic [4*W-1:0] wdat_q;
   logic [4*L-1:0] wen_q;
   logic [W-1:0] d_q;
   logic [L-1:0] bws_n_q;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wseq_q <= 3'h0;
         wdat_q <= '0;
         wen_q <= '0;
         d_q <= '0;
         bws_n_q <= '1;
      end else begin
         // words follow one cycle after the start cycle
         if (o_wr_ack) begin
            wseq_q <= 3'h1;
            wdat_q <= i_wr_data;
            wen_q <= i_wr_lane_en;
         end else if (wseq_q != 3'h0) begin
            wseq_q <= (wseq_q == 3'h5) ? 3'h0 : wseq_q + 3'h1;
         end
         if (wseq_q >= 3'h1 && wseq_q <= 3'h4) begin
            d_q <= wdat_q[int'(wseq_q - 3'h1)*W +: W]; // RL21 RL22
            bws_n_q <= ~wen_q[int'(wseq_q - 3'h1)*L +: L];
         end else begin
            bws_n_q <= '1;
         end
      end
   end

   // ----------------------------------------
   // read data collection
   // ----------------------------------------
   logic [1:0] rslot_q;
   logic [3*W-1:0] rbuf_q;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rslot_q <= 2'h0;
         rbuf_q <= '0;
         o_rd_valid <= 1'b0;
         o_rd_data <= '0;
      end else begin
         o_rd_valid <= 1'b0;
         if (bus.q_oe) begin
            rslot_q <= rslot_q + 2'h1;
            if (rslot_q == 2'h3) begin
               o_rd_valid <= 1'b1;
               o_rd_data <= {bus.q, rbuf_q};
            end else begin
               rbuf_q[int'(rslot_q)*W +: W] <= bus.q;
            end
         end
      end
   end

   assign bus.k_pos = kpos_q;
   assign bus.c_pos = cp_q;
   assign bus.c_neg = cn_q;
   assign bus.read_port_select_n = rps_n_q;
   assign bus.write_port_select_n = wps_n_q;
   assign bus.addr = addr_q;
   assign bus.d = d_q;
   assign bus.byte_lane_write_select_n = bws_n_q;
endmodule // dpb4_ctrl
`default_nettype wire

// File: dpb4_device.sv
`timescale 1ns/1ns
`default_nettype none
`include "dpb4_params.svh"
module dpb4_device
   import dpb4_pkg::*;
#(
   parameter int AW = `DPB4_ADDR_W,
   parameter int W = `DPB4_WORD_W,
   parameter int L = `DPB4_LANES,
   parameter int IMP_PERIOD = `DPB4_IMP_PERIOD
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   dpb4_if.dev bus,
   output logic o_single_clk,
   output logic o_imp_update
);
   localparam int LW = W / L;

   // ----------------------------------------
   // single clock strap
   // ----------------------------------------
   logic [1:0] strap_cnt_q;
   logic single_q;
   logic out_edge;
   logic out_pos;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         strap_cnt_q <= 2'h0;
         single_q <= 1'b0;
      end else if (strap_cnt_q != `DPB4_STRAP_DLY) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         single_q <= bus.c_pos & bus.c_neg; // RL15
      end
   end

   // output timing reference: k pair in single mode, else c pair
   assign out_edge = single_q ? 1'b1 : (bus.c_pos | bus.c_neg); // RL4
   assign out_pos = single_q ? bus.k_pos : bus.c_pos;
   assign o_single_clk = single_q;

   // ----------------------------------------
   // start arbitration
   // ----------------------------------------
   dpb4_start_t prev_q;
   dpb4_start_t start_d;

   always_comb begin
      start_d = DPB4_NONE;
      if (bus.k_pos) begin // RL1 RL19
         if (!bus.read_port_select_n && prev_q != DPB4_READ) begin // RL8 RL18
            start_d = DPB4_READ;
         end else if (!bus.write_port_select_n &&
                      prev_q != DPB4_WRITE) begin // RL12 RL18
            start_d = DPB4_WRITE;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         prev_q <= DPB4_NONE; // RL23
      end else if (bus.k_pos) begin
         prev_q <= start_d;
      end
   end

   // ----------------------------------------
   // read side
   // ----------------------------------------
   logic rd_pend_q;
   logic [AW-1:0] rd_addr_q;
   logic rd_run_q;
   logic [1:0] rd_idx_q;
   logic [AW-1:0] rd_base_q;
   logic burst_begin;
   logic emit;
   logic [AW-1:0] emit_addr;
   logic [1:0] emit_idx;
   logic [W-1:0] arr_word;
   logic [W-1:0] fwd_word;
   logic [W-1:0] q_q;
   logic q_oe_q;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_pend_q <= 1'b0;
         rd_addr_q <= '0;
      end else if (bus.k_pos) begin
         rd_pend_q <= (start_d == DPB4_READ);
         if (start_d == DPB4_READ) begin
            rd_addr_q <= bus.addr; // RL6
         end
      end
   end

   // burst starts at the positive rise of cycle t+1
   assign burst_begin = bus.k_pos && rd_pend_q; // RL22
   assign emit = burst_begin || (rd_run_q && out_edge); // RL7
   assign emit_addr = burst_begin ? rd_addr_q : rd_base_q;
   assign emit_idx = burst_begin ? 2'h0 : rd_idx_q; // RL21

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_run_q <= 1'b0;
         rd_idx_q <= 2'h0;
         rd_base_q <= '0;
      end else if (emit) begin
         rd_idx_q <= emit_idx + 2'h1;
         rd_run_q <= (emit_idx != 2'h3); // RL2
         if (burst_begin) begin
            rd_base_q <= rd_addr_q;
         end
      end
   end

   // ----------------------------------------
   // write side
   // ----------------------------------------
   logic wr_pend_q;
   logic [AW-1:0] wr_addr_q;
   logic wr_cap_q;
   logic [1:0] wr_idx_q;
   logic [AW-1:0] wbuf_addr_q;
   logic [4*W-1:0] wbuf_q;
   logic [4*L-1:0] wmask_q;
   logic cap_begin;
   logic cap;
   logic [1:0] cap_idx;
   logic commit;
   logic [4*W-1:0] commit_data;
   logic [4*L-1:0] commit_mask;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else if (bus.k_pos) begin
         wr_pend_q <= (start_d == DPB4_WRITE);
         if (start_d == DPB4_WRITE) begin
            wr_addr_q <= bus.addr; // RL10
         end
      end
   end

   // data inputs are only looked at inside a capture window
   assign cap_begin = bus.k_pos && wr_pend_q; // RL22 RL13 RL24
   assign cap = cap_begin || wr_cap_q; // RL3
   assign cap_idx = cap_begin ? 2'h0 : wr_idx_q;
   assign commit = cap && (cap_idx == 2'h3); // RL11

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_cap_q <= 1'b0;
         wr_idx_q <= 2'h0;
         wbuf_addr_q <= '0;
         wbuf_q <= '0;
         wmask_q <= '0;
      end else if (cap) begin
         wr_idx_q <= cap_idx + 2'h1;
         wr_cap_q <= (cap_idx != 2'h3);
         wbuf_q[int'(cap_idx)*W +: W] <= bus.d;
         if (cap_begin) begin
            wbuf_addr_q <= wr_addr_q;
            wmask_q <= {{(3*L){1'b0}}, ~bus.byte_lane_write_select_n}; // RL5
         end else begin
            wmask_q[int'(cap_idx)*L +: L] <= ~bus.byte_lane_write_select_n;
         end
      end
   end

   always_comb begin
      commit_data = wbuf_q;
      commit_mask = wmask_q;
      commit_data[3*W +: W] = bus.d;
      commit_mask[3*L +: L] = ~bus.byte_lane_write_select_n; // RL14
   end

   dpb4_array #(
      .AW(AW),
      .W(W),
      .L(L)
   ) u_array (
      .i_core_clk(i_core_clk),
      .i_we(commit),
      .i_waddr(wbuf_addr_q),
      .i_wdata(commit_data),
      .i_wmask(commit_mask),
      .i_raddr(emit_addr),
      .i_ridx(emit_idx),
      .o_rdata(arr_word)
   );

   // ----------------------------------------
   // forwarding and output register
   // ----------------------------------------
   always_comb begin
      fwd_word = arr_word;
      for (int j = 0; j < L; j++) begin
         if (wbuf_addr_q == emit_addr &&
             wmask_q[int'(emit_idx)*L+j]) begin // RL16
            fwd_word[j*LW +: LW] = wbuf_q[int'(emit_idx)*W+j*LW +: LW];
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q_q <= '0;
      end else if (emit) begin
         q_q <= fwd_word; // RL7
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q_oe_q <= 1'b0; // RL23
      end else if (emit) begin
         q_oe_q <= 1'b1;
      end else if (out_pos) begin
         q_oe_q <= 1'b0; // RL9 RL24
      end
   end

   assign bus.q = q_q;
   assign bus.q_oe = q_oe_q;

   // ----------------------------------------
   // impedance update tick
   // ----------------------------------------
   logic [$clog2(IMP_PERIOD)-1:0] imp_cnt_q;
   logic imp_q;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         imp_cnt_q <= '0;
         imp_q <= 1'b0;
      end else if (bus.k_pos) begin
         imp_q <= (imp_cnt_q == ($clog2(IMP_PERIOD))'(IMP_PERIOD - 1)); // RL20
         imp_cnt_q <= imp_cnt_q + 1'b1;
      end else begin
         imp_q <= 1'b0;
      end
   end

   assign o_imp_update = imp_q;
endmodule // dpb4_device
`default_nettype wire

// File: dpb4_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dpb4_if #(
   parameter int AW = 8,
   parameter int W = 18,
   parameter int L = 2
);
   logic k_pos;
   logic c_pos;
   logic c_neg;
   logic read_port_select_n;
   logic write_port_select_n;
   logic [AW-1:0] addr;
   logic [W-1:0] d;
   logic [L-1:0] byte_lane_write_select_n;
   logic [W-1:0] q;
   logic q_oe;
   modport dev (
      input k_pos, c_pos, c_neg, read_port_select_n, write_port_select_n,
      input addr, d, byte_lane_write_select_n,
      output q, q_oe
   );
   modport ctrl (
      output k_pos, c_pos, c_neg, read_port_select_n, write_port_select_n,
      output addr, d, byte_lane_write_select_n,
      input q, q_oe
   );
endinterface
`default_nettype wire

// File: dpb4_params.svh
// Functional notes
// RL1: accesses start only on positive input clock rise
// RL2: each access moves four words over two cycles
// RL3: write data captured on both input clock rises
// RL4: read data launched on output clock pair rises
// RL5: port and lane selects registered on input clocks
// RL6: read select at rise latches read address
// RL7: lowest word first, then one per output edge
// RL8: read request right after read start ignored
// RL9: read deselect finishes burst, then outputs float
// RL10: write select at rise latches write address
// RL11: four words latched, then 72 bits committed
// RL12: write request right after write start ignored
// RL13: write deselect completes pending write, ignores inputs
// RL14: lane selects mask each word's written lanes
// RL15: both output clocks high at start: single clock
// RL16: same-location read returns newest, forwarded write data
// RL17: controller starts one transaction per cycle only
// RL18: both selected: read unless previous start was read
// RL19: selects sampled on positive rise only, independent ports
// RL20: impedance update once every 1024 clock cycles
// RL21: burst word order 00, 01, 10, 11
// RL22: data moves in cycles t+1 and t+2
// RL23: power-on deselected with outputs high impedance
// RL24: no select: no operation, outputs high impedance
`ifndef DPB4_PARAMS_SVH
`define DPB4_PARAMS_SVH
`define DPB4_WORD_W 18
`define DPB4_LANES 2
`define DPB4_ADDR_W 8
`define DPB4_BURST 4
`define DPB4_IMP_PERIOD 1024
`define DPB4_STRAP_DLY 2'h2
`endif

// File: dpb4_pkg.sv
package dpb4_pkg;
   typedef enum logic [1:0] {
      DPB4_NONE  = 2'b00,
      DPB4_READ  = 2'b01,
      DPB4_WRITE = 2'b10
   } dpb4_start_t;
endpackage

// File: dual_port_burst4_sram_if_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dual_port_burst4_sram_if_tb;
   localparam int W = 18;
   localparam int L = 2;
   localparam int AW = 8;
   localparam int IMP = 8;
   localparam logic [4*W-1:0] D1 = 72'h1A2B3C4D5E6F708192;
   localparam logic [4*W-1:0] D2 = 72'hF0E1D2C3B4A5968778;
   logic i_core_clk;
   logic i_resetn;
   logic rd_req;
   logic wr_req;
   logic [AW-1:0] rd_addr;
   logic [AW-1:0] wr_addr;
   logic [4*W-1:0] wr_data;
   logic [4*W-1:0] rd_data;
   logic [4*L-1:0] lane_en;
   logic rd_ack, wr_ack, rd_valid, single, imp, single2;
   int n_errors;
   int checks_done;
   int i;
   int n;
   dpb4_if #(.AW(AW), .W(W), .L(L)) bus ();
   dpb4_if #(.AW(AW), .W(W), .L(L)) bus2 ();
   dpb4_device #(.IMP_PERIOD(IMP)) dpb4_device_inst (.i_core_clk(i_core_clk),
      .i_resetn(i_resetn), .bus(bus.dev), .o_single_clk(single),
      .o_imp_update(imp));
   dpb4_device #(.IMP_PERIOD(IMP)) dpb4_device_inst_b (
      .i_core_clk(i_core_clk), .i_resetn(i_resetn), .bus(bus2.dev),
      .o_single_clk(single2), .o_imp_update());
   dpb4_ctrl dpb4_ctrl_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
      .i_single_clk(1'b0), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
      .i_wr_req(wr_req), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
      .i_wr_lane_en(lane_en), .o_rd_ack(rd_ack), .o_wr_ack(wr_ack),
      .o_rd_valid(rd_valid), .o_rd_data(rd_data), .bus(bus.ctrl));
   dpb4_asserts #(.L(L)) dpb4_asserts_inst (.i_core_clk(i_core_clk),
      .i_resetn(i_resetn), .k_pos(bus.k_pos), .c_pos(bus.c_pos),
      .c_neg(bus.c_neg), .read_port_select_n(bus.read_port_select_n),
      .write_port_select_n(bus.write_port_select_n),
      .byte_lane_write_select_n(bus.byte_lane_write_select_n),
      .q_oe(bus.q_oe));
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic hang();
      n_errors++;
      print_verdict();
   endtask
   task automatic check_eq(input logic [4*W-1:0] seen,
      input logic [4*W-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // per-lane merge of new data over old, 9-bit lanes
   function automatic logic [4*W-1:0] merge(input logic [4*W-1:0] o,
      input logic [4*W-1:0] nw, input logic [4*L-1:0] en);
      merge = o;
      for (int j = 0; j < 4*L; j++) begin
         if (en[j]) merge[j*9+:9] = nw[j*9+:9];
      end
   endfunction
   task automatic wr(input logic [AW-1:0] a, input logic [4*W-1:0] dd,
      input logic [4*L-1:0] en);
      int k;
      wr_req <= 1'b1;
      wr_addr <= a;
      wr_data <= dd;
      lane_en <= en;
      for (k = 0; k < 20; k++) begin
         @(posedge i_core_clk);
         if (wr_ack === 1'b1) break;
      end
      wr_req <= 1'b0;
      if (k == 20) hang();
   endtask
   task automatic rd(input logic [AW-1:0] a, input logic [4*W-1:0] exp);
      int k;
      int m;
      m = 0;
      rd_req <= 1'b1;
      rd_addr <= a;
      for (k = 0; k < 20; k++) begin
         @(posedge i_core_clk);
         if (rd_ack === 1'b1) break;
      end
      rd_req <= 1'b0;
      if (k == 20) hang();
      for (k = 0; k < 20; k++) begin
         @(posedge i_core_clk);
         if (bus.q_oe === 1'b1 && m < 4) begin
            check_eq(72'(bus.q), 72'(exp[m*W+:W]));
            m++;
         end
         if (rd_valid === 1'b1) break;
      end
      check_eq(rd_data, exp);
      check_eq(72'(m), 72'h4);
      if (k == 20) hang();
   endtask
   // ------------------------------------------------
   // stimulus
   // ------------------------------------------------
   initial begin
      i_core_clk = 1'b0;
      forever #20 i_core_clk = ~i_core_clk;
   end
   initial begin
      n_errors = 0;
      checks_done = 0;
      i_resetn = 1'b0;
      rd_req = 1'b0;
      wr_req = 1'b0;
      rd_addr = 8'h00;
      wr_addr = 8'h00;
      wr_data = 72'h0;
      lane_en = 8'h00;
      bus2.k_pos = 1'b0;
      bus2.c_pos = 1'b1;
      bus2.c_neg = 1'b1;
      bus2.read_port_select_n = 1'b1;
      bus2.write_port_select_n = 1'b1;
      bus2.addr = 8'h00;
      bus2.d = 18'h0;
      bus2.byte_lane_write_select_n = 2'h3;
      repeat (6) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      @(posedge i_core_clk);
      check_eq(72'(bus.q_oe), 72'h0);
      repeat (3) @(posedge i_core_clk);
      check_eq(72'(single), 72'h0);
      check_eq(72'(single2), 72'h1);
      $display("test power_on done");
      wr(8'h05, D1, 8'hFF);
      rd(8'h05, D1);
      $display("test write_read done");
      wr(8'h05, D2, 8'hC9);
      rd(8'h05, merge(D1, D2, 8'hC9));
      $display("test lane_mask done");
      fork
         wr(8'h09, D2, 8'hFF);
         begin
            repeat (2) @(posedge i_core_clk);
            rd(8'h09, D2);
         end
      join
      $display("test forwarding done");
      for (i = 0; i < 100; i++) begin
         @(posedge i_core_clk);
         if (imp === 1'b1) break;
      end
      if (i == 100) hang();
      for (n = 1; n < 100; n++) begin
         @(posedge i_core_clk);
         if (imp === 1'b1) break;
      end
      check_eq(72'(n), 72'(2*IMP));
      $display("test impedance done");
      // both selects twice from idle, then read back the write
      n = 0;
      for (i = 0; i < 16; i++) begin
         bus2.k_pos <= !i[0];
         bus2.read_port_select_n <= !(i == 0 || i == 2 || i == 8);
         bus2.write_port_select_n <= !(i == 0 || i == 2 || i == 4);
         bus2.addr <= (i == 0) ? 8'h03 : 8'h07;
         bus2.d <= D1[(i&3)*W+:W];
         bus2.byte_lane_write_select_n <= (i >= 4 && i < 8) ? 2'h0 : 2'h3;
         @(posedge i_core_clk);
         if (bus2.q_oe === 1'b1) n++;
         if (i >= 11 && i < 15) begin
            check_eq(72'(bus2.q), 72'(D1[((i+1)&3)*W+:W]));
         end
      end
      check_eq(72'(n), 72'h8);
      $display("test arbitration done");
      print_verdict();
   end
endmodule // dual_port_burst4_sram_if_tb
`default_nettype wire
